// >>> hdl/npr_bank.sv
// Oscillator frequency and phase preset register bank with AXI4-Lite slave
// Function
// RULE1 - Channel A preset 3 frequency is a 32-bit read/write word resetting to C0000000.
// RULE2 - Channel A preset 3 phase is a 16-bit read/write word resetting to zero.
// RULE3 - Channel B presets 0 to 2 frequencies are 32-bit read/write words resetting to C0000000.
// RULE4 - Channel B presets 0 and 1 phases are 16-bit read/write words resetting to zero.
// RULE5 - In interleaved single-channel mode every channel B preset is ignored.
// RULE6 - In interleaved single-channel mode the oscillator uses only channel A presets.
// RULE7 - Each preset takes an 8-byte slot, frequency at base, phase 4 above, from 238.
// RULE8 - Each 16-bit phase is left-aligned into 32 bits for the phase accumulator.
// RULE9 - Software computes the frequency word as 2^32 times oscillator over sample rate.
// RULE10 - Software should resynchronise the oscillator after a running frequency change.
// RULE11 - The bank presents the selected preset of each channel to the oscillator.
`timescale 1ns/1ps
`default_nettype none
module npr_bank (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [11:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [11:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [1:0]             preset_sel_a,
    input  wire logic [1:0]             preset_sel_b,
    output npr_pkg::npr_osc_word_t      osc_chan_a,
    output npr_pkg::npr_osc_word_t      osc_chan_b,
    output logic                        osc_chan_b_valid,
    output logic                        interleave_mode
);
    import npr_pkg::*;

    // Register map, byte addresses, one aligned word each:
    //   0x238  channel A preset 3 frequency, 32 bits
    //   0x23C  channel A preset 3 phase, low 16 bits
    //   0x240  channel B preset 0 frequency, 32 bits
    //   0x244  channel B preset 0 phase, low 16 bits
    //   0x248  channel B preset 1 frequency, 32 bits
    //   0x24C  channel B preset 1 phase, low 16 bits
    //   0x250  channel B preset 2 frequency, 32 bits
    //   0x260  mode control, bit 0 selects interleaved single-channel mode
    // Every other word answers with a slave error; a write there stores nothing.
    // The two low address bits are ignored, so byte addresses alias to words.
    //
    // Values after reset:
    //   frequency words  C000_0000
    //   phase words      0000
    //   mode bit         0, both channels in use
    //   oscillator words frequency C000_0000, phase 0
    //   channel B valid  low during reset, high one edge after release
    //
    // Write timing, in clock edges:
    //   edge 0  address and data taken, in either order or together
    //   edge 1  the word is stored and the response raised
    //   edge 2  response taken once the master is ready
    // A second write is refused until the response has gone.
    // Byte strobes are honoured; phase words keep only their low half.
    //
    // Read timing, in clock edges:
    //   edge 0  address taken and the word selected
    //   edge 1  data and response stand until the master is ready
    // A second read is refused while the data still stands.
    // Phase words read back in the low half with the upper half zero.
    //
    // Oscillator side:
    //   words follow a register or select change one edge later
    //   phase is handed over left-aligned, one step is 2^-16 of a turn
    //   presets held in a neighbouring bank show their reset values here
    //   in interleaved mode channel B mirrors channel A, valid is low
    //   channel B registers keep what software wrote even when unused
    //
    // Limitations for software:
    //   frequency changes reach the oscillator at once, with no retiming
    //   the phase after such a change is not known until a resync
    //   preset selects are taken as they come, same clock, no filtering
    //
    // Trade-offs:
    //   both bus channels are held in single-entry stages, so at most
    //   one write and one read are in flight; this keeps the bank small
    //   at the price of one idle edge between back-to-back reads and two between back-to-back writes

    // Preset storage
    logic [31:0] freq_a3_reg;
    logic [15:0] phase_a3_reg;
    logic [31:0] freq_b0_reg;
    logic [15:0] phase_b0_reg;
    logic [31:0] freq_b1_reg;
    logic [15:0] phase_b1_reg;
    logic [31:0] freq_b2_reg;
    logic        mode_reg;

    // Write channel capture
    logic [11:0] aw_addr_reg;
    logic        aw_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        w_full_reg;
    logic        do_write;
    logic        wr_hit;

    // Read channel
    logic [31:0] rd_next;
    logic        rd_hit;

    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_full_reg && w_full_reg && !s_axi_bvalid;

    // Address and data may arrive in either order; hold each until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 12'h0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end

    // Byte-lane merge helpers
    function automatic logic [31:0] merge32(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge32

    // Slot decode on the word address, low two bits ignored
    always_comb begin
        case ({aw_addr_reg[11:2], 2'b00})
            OFF_FREQ_A3, OFF_PHASE_A3, OFF_FREQ_B0, OFF_PHASE_B0,
            OFF_FREQ_B1, OFF_PHASE_B1, OFF_FREQ_B2, OFF_MODE_CTRL: wr_hit = 1'b1; // see RULE7
            default: wr_hit = 1'b0;
        endcase
    end

    // Word address of the held write
    logic [11:0] wr_word;
    assign wr_word = {aw_addr_reg[11:2], 2'b00};

    // Channel A preset 3 frequency word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_a3_reg <= FREQ_RESET;                                        // see RULE1
        end else if (do_write && wr_word == OFF_FREQ_A3) begin
            freq_a3_reg <= merge32(freq_a3_reg, w_data_reg, w_strb_reg);      // see RULE1
        end
    end

    // Channel A preset 3 phase word, low half of the bus word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_a3_reg <= PHASE_RESET;                                      // see RULE2
        end else if (do_write && wr_word == OFF_PHASE_A3) begin
            phase_a3_reg <= 16'(merge32({16'h0000, phase_a3_reg},
                                        w_data_reg, w_strb_reg));             // see RULE2
        end
    end

    // Channel B preset 0 frequency word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_b0_reg <= FREQ_RESET;                                        // see RULE3
        end else if (do_write && wr_word == OFF_FREQ_B0) begin
            freq_b0_reg <= merge32(freq_b0_reg, w_data_reg, w_strb_reg);      // see RULE3
        end
    end

    // Channel B preset 0 phase word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_b0_reg <= PHASE_RESET;                                      // see RULE4
        end else if (do_write && wr_word == OFF_PHASE_B0) begin
            phase_b0_reg <= 16'(merge32({16'h0000, phase_b0_reg},
                                        w_data_reg, w_strb_reg));             // see RULE4
        end
    end

    // Channel B preset 1 frequency word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_b1_reg <= FREQ_RESET;                                        // see RULE3
        end else if (do_write && wr_word == OFF_FREQ_B1) begin
            freq_b1_reg <= merge32(freq_b1_reg, w_data_reg, w_strb_reg);      // see RULE3
        end
    end

    // Channel B preset 1 phase word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_b1_reg <= PHASE_RESET;                                      // see RULE4
        end else if (do_write && wr_word == OFF_PHASE_B1) begin
            phase_b1_reg <= 16'(merge32({16'h0000, phase_b1_reg},
                                        w_data_reg, w_strb_reg));             // see RULE4
        end
    end

    // Channel B preset 2 frequency word; its phase lives elsewhere
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_b2_reg <= FREQ_RESET;                                        // see RULE3
        end else if (do_write && wr_word == OFF_FREQ_B2) begin
            freq_b2_reg <= merge32(freq_b2_reg, w_data_reg, w_strb_reg);      // see RULE3
        end
    end

    // Mode bit, only lane 0 carries it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= 1'b0;
        end else if (do_write && wr_word == OFF_MODE_CTRL && w_strb_reg[0]) begin
            mode_reg <= w_data_reg[0];                                        // see RULE5
        end
    end

    // Write response, error for unmapped slots
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read mux; phase words read back in the low half, upper bits zero
    always_comb begin
        rd_hit  = 1'b1;
        rd_next = 32'h0000_0000;
        case ({s_axi_araddr[11:2], 2'b00})
            OFF_FREQ_A3:   rd_next = freq_a3_reg;
            OFF_PHASE_A3:  rd_next = {16'h0000, phase_a3_reg};
            OFF_FREQ_B0:   rd_next = freq_b0_reg;
            OFF_PHASE_B0:  rd_next = {16'h0000, phase_b0_reg};
            OFF_FREQ_B1:   rd_next = freq_b1_reg;
            OFF_PHASE_B1:  rd_next = {16'h0000, phase_b1_reg};
            OFF_FREQ_B2:   rd_next = freq_b2_reg;
            OFF_MODE_CTRL: rd_next = {31'h0000_0000, mode_reg};
            default:       rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_next;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Oscillator word selection; presets held in a neighbouring bank
    // present their reset values, since they are not seen here
    npr_osc_word_t osc_a_next;
    npr_osc_word_t osc_b_next;
    npr_osc_word_t osc_reset_word;
    assign osc_reset_word = '{freq: FREQ_RESET, phase: 32'h0000_0000};

    // Channel A: only preset 3 is held here
    always_comb begin
        osc_a_next = osc_reset_word;
        if (preset_sel_a == 2'd3) begin                                       // see RULE11
            osc_a_next = '{freq: freq_a3_reg, phase: {phase_a3_reg, 16'h0000}}; // see RULE8
        end
    end

    // Channel B: own presets, or a copy of channel A while interleaved
    always_comb begin
        osc_b_next = osc_reset_word;
        if (mode_reg) begin
            osc_b_next = osc_a_next;                                          // see RULE5 RULE6
        end else begin
            case (preset_sel_b)                                               // see RULE11
                2'd0: osc_b_next = '{freq: freq_b0_reg, phase: {phase_b0_reg, 16'h0000}};
                2'd1: osc_b_next = '{freq: freq_b1_reg, phase: {phase_b1_reg, 16'h0000}};
                2'd2: osc_b_next = '{freq: freq_b2_reg, phase: 32'h0000_0000};
                default: osc_b_next = osc_reset_word;
            endcase
        end
    end

    // Registered words to the oscillator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_chan_a       <= osc_reset_word;
            osc_chan_b       <= osc_reset_word;
            osc_chan_b_valid <= 1'b0;
        end else begin
            osc_chan_a       <= osc_a_next;
            osc_chan_b       <= osc_b_next;
            osc_chan_b_valid <= !mode_reg;                                    // see RULE5
        end
    end

    assign interleave_mode = mode_reg;
endmodule : npr_bank
`default_nettype wire

// >>> hdl/npr_pkg.sv
// Package for the oscillator preset register bank: offsets, resets, carriers
package npr_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_FREQ_A3  = 12'h0238;
    localparam logic [11:0] OFF_PHASE_A3 = 12'h023C;
    localparam logic [11:0] OFF_FREQ_B0  = 12'h0240;
    localparam logic [11:0] OFF_PHASE_B0 = 12'h0244;
    localparam logic [11:0] OFF_FREQ_B1  = 12'h0248;
    localparam logic [11:0] OFF_PHASE_B1 = 12'h024C;
    localparam logic [11:0] OFF_FREQ_B2  = 12'h0250;
    // Mode control register of our own
    localparam logic [11:0] OFF_MODE_CTRL = 12'h0260;

    // Values after reset
    localparam logic [31:0] FREQ_RESET  = 32'hC000_0000;
    localparam logic [15:0] PHASE_RESET = 16'h0000;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Preset words handed to the oscillator for one channel
    typedef struct packed {
        logic [31:0] freq;
        logic [31:0] phase;
    } npr_osc_word_t;
endpackage : npr_pkg

// >>> test/npr_bank_assertions.sv
// Concurrent property checker for the oscillator preset register bank
`timescale 1ns/1ps
`default_nettype none
module npr_bank_assertions (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic [11:0]            s_axi_araddr,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic [1:0]             s_axi_rresp,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire npr_pkg::npr_osc_word_t osc_chan_a,
    input wire npr_pkg::npr_osc_word_t osc_chan_b,
    input wire logic                   osc_chan_b_valid,
    input wire logic                   interleave_mode
);
    import npr_pkg::*;
    // One domain, so clock and reset are given once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_ar_ans: assert property (p_ar_ans) else $error("read not answered");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken early");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    // Phase words read back with an empty upper half
    property p_phase_rd; s_axi_arvalid && s_axi_arready && s_axi_araddr[2]
        && s_axi_araddr[11:4] inside {8'h23, 8'h24} |=> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_phase_rd: assert property (p_phase_rd) else $error("phase upper bits set");
    property p_unmapped; s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0254
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole not refused");
    property p_align; osc_chan_a.phase[15:0] == 16'h0000 && osc_chan_b.phase[15:0] == 16'h0000;
    endproperty
    a_align: assert property (p_align) else $error("phase not left aligned");
    property p_b_off; interleave_mode |=> !osc_chan_b_valid; endproperty
    a_b_off: assert property (p_b_off) else $error("channel b used");
    // Needs the mode to have settled one cycle before the words follow it
    property p_mirror; interleave_mode && $past(interleave_mode) |-> osc_chan_b == osc_chan_a;
    endproperty
    a_mirror: assert property (p_mirror) else $error("channel b not from a");
endmodule : npr_bank_assertions

bind npr_bank npr_bank_assertions i_npr_bank_assertions (.aclk(aclk), .aresetn(aresetn),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .osc_chan_a(osc_chan_a), .osc_chan_b(osc_chan_b),
    .osc_chan_b_valid(osc_chan_b_valid), .interleave_mode(interleave_mode));
`default_nettype wire

// >>> test/npr_bank_bench.sv
// Self-checking bench for the oscillator preset register bank
`timescale 1ns/1ps
`default_nettype none
module npr_bank_bench;
    import npr_pkg::*;
    logic          aclk = 0, aresetn = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
    logic          awrdy, wrdy, bv, arrdy, rv, bval, ilv;
    logic [1:0]    bresp, rresp, r, sel_a = '0, sel_b = '0;
    logic [3:0]    wstrb = 4'hF;
    logic [11:0]   awaddr = '0, araddr = '0;
    logic [31:0]   wdata = '0, rdata, d, m[7], seed = 32'h198f_d288;
    npr_osc_word_t osc_a, osc_b;
    logic [11:0]   regs[7] = '{OFF_FREQ_A3, OFF_PHASE_A3, OFF_FREQ_B0, OFF_PHASE_B0,
                               OFF_FREQ_B1, OFF_PHASE_B1, OFF_FREQ_B2};
    int            errors = 0, compares = 0;

    // 10 MHz clock
    always #50 aclk = ~aclk;

    npr_bank i_npr_bank (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .preset_sel_a(sel_a), .preset_sel_b(sel_b), .osc_chan_a(osc_a), .osc_chan_b(osc_b),
        .osc_chan_b_valid(bval), .interleave_mode(ilv));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Address and data offered together, each dropped once taken
    // Handshakes judged on settled values mid-cycle, acted on at the next edge
    task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        {awaddr, wdata, awv, wv, brdy} <= {a, v, 3'h7};
        do begin
            @(negedge aclk);
            {aw_t, w_t, b_t} = {awv && awrdy, wv && wrdy, bv};
            resp = bresp;
            @(posedge aclk);
            if (aw_t) awv <= 1'b0;
            if (w_t) wv <= 1'b0;
        end while (!b_t);
        brdy <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
        logic ar_t, r_t;
        @(posedge aclk);
        {araddr, arv, rrdy} <= {a, 2'h3};
        do begin
            @(negedge aclk);
            {ar_t, r_t} = {arv && arrdy, rv};
            {v, resp} = {rdata, rresp};
            @(posedge aclk);
            if (ar_t) arv <= 1'b0;
        end while (!r_t);
        rrdy <= 1'b0;
    endtask : rd

    task automatic tally_and_finish;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        for (int i = 0; i < 7; i++) m[i] = i[0] ? 32'h0000_0000 : FREQ_RESET;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(regs[i], d, r);
            chk({r, d}, {RESP_OKAY, m[i]});
        end
        $display("reset test done");
        // Random words into all seven preset words; phase words keep only their low half
        for (int i = 0; i < 7; i++) begin
            seed = lfsr(seed);
            wr(regs[i], seed, r);
            chk(r, RESP_OKAY);
            m[i] = i[0] ? {16'h0000, seed[15:0]} : seed;
        end
        for (int i = 0; i < 7; i++) begin
            rd(regs[i], d, r);
            chk(d, m[i]);
        end
        wr(12'h0254, seed, r);
        chk(r, RESP_SLVERR);
        rd(12'h0254, d, r);
        chk({r, d}, {RESP_SLVERR, 32'h0000_0000});
        $display("readback test done");
        // Every select value; unheld presets show reset words
        for (int s = 0; s < 4; s++) begin
            {sel_a, sel_b} <= {s[1:0], s[1:0]};
            repeat (3) @(posedge aclk);
            chk(osc_a, s == 3 ? {m[0], m[1][15:0], 16'h0} : {FREQ_RESET, 32'h0});
            chk({bval, osc_b}, s < 3 ? {1'b1, m[2 + 2 * s], s < 2 ? m[3 + 2 * s][15:0] : 16'h0,
                16'h0} : {1'b1, FREQ_RESET, 32'h0});
        end
        $display("select test done");
        // Channel B writes must not leak while interleaved
        sel_b <= 2'h0;
        wr(OFF_MODE_CTRL, 32'h0000_0001, r);
        seed = lfsr(seed);
        // Changed only while unused, so no oscillator resync is owed
        wr(OFF_FREQ_B0, seed, r);
        m[2] = seed;
        repeat (3) @(posedge aclk);
        chk({ilv, bval, osc_b}, {2'b10, m[0], m[1][15:0], 16'h0});
        wr(OFF_MODE_CTRL, 32'h0000_0000, r);
        repeat (3) @(posedge aclk);
        chk({ilv, bval, osc_b}, {2'b01, m[2], m[3][15:0], 16'h0});
        $display("interleave test done");
        tally_and_finish();
    end

    // Watchdog well beyond the hundred or so cycles the tests need
    initial begin
        repeat (3000) @(posedge aclk);
        errors++;
        tally_and_finish();
    end
endmodule : npr_bank_bench
`default_nettype wire
